/* File: logic/osc_tick_gen.sv */
// Tick generator modelling the 1 MHz calibrated oscillator
`timescale 1ns/1ps
module osc_tick_gen
  import storage_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  output logic tick
);
  logic [5:0] div_r;
  localparam logic [5:0] DIV_LAST = 6'(CLK_PER_OSC - 1);

  // Divide the CPU clock down to one tick per oscillator period
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      div_r <= 6'h00;
      tick <= 1'b0;
    end else if (ce) begin
      tick <= (div_r == DIV_LAST);
      div_r <= (div_r == DIV_LAST) ? 6'h00 : div_r + 6'h01;
    end
  end
endmodule

/* File: logic/storage_access.sv */
// CPU access controller for the byte-wide nonvolatile data storage
// How it works
// - Ten-bit byte address from low plus two high bits
// - Data buffer holds write byte, receives read byte
// - Control bit 3 with global enable gates irq
// - Ready irq is level while strobe low
// - Write starts only if armed when strobed
// - Arm bit self-clears four cycles after set
// - No write while flash self-programming is active
// - Write strobe stays set until write time ends
// - Write strobe stalls CPU two cycles
// - Read strobe fetches byte within one instruction
// - Read stalls CPU four cycles
// - During write, reads refused, address frozen
// - Write time counts 8448 oscillator cycles
// - Registers at I/O 0x1c-0x1f, data space +0x20
`timescale 1ns/1ps
module storage_access
  import storage_pkg::*;
#(
  parameter int WRITE_OSC_COUNT = WRITE_OSC_CYCLES
)
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic io_sel,
  input wire logic [6:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  input wire logic global_irq_enable,
  input wire logic self_program_active,
  output logic cpu_stall,
  output logic ready_irq,
  output logic [ADDR_W-1:0] cell_addr,
  output logic [7:0] cell_wdata,
  output logic cell_we,
  output logic cell_re,
  input wire logic [7:0] cell_rdata
);
  typedef enum logic [1:0] {IDLE, WRITING} wr_state_e;
  wr_state_e state_r;
  logic [7:0] addr_lo_r;
  logic [HI_ADDR_BITS-1:0] addr_hi_r;
  logic [7:0] data_r;
  logic rie_r, arm_r, strobe_r;
  logic [2:0] arm_cnt_r, stall_cnt_r;
  logic [13:0] osc_cnt_r;
  logic osc_tick;
  logic [5:0] reg_idx;
  logic wr_ctl, wr_data, wr_lo, wr_hi, rd_trig, wr_start, busy;

  // Map an I/O or data-space address onto a register offset
  function automatic logic [5:0] io_index(input logic sel,
                                          input logic [6:0] a);
    io_index = sel ? a[5:0] : 6'(a - DATA_SPACE_OFFSET);
  endfunction

  // Decode one register write
  function automatic logic hit(input logic [5:0] idx,
                               input logic [5:0] off,
                               input logic wr);
    hit = wr && (idx == off);
  endfunction

  osc_tick_gen u_osc (
    .ref_clk(ref_clk),
    .rst(rst),
    .ce(ce),
    .tick(osc_tick)
  );

  // Register decode for both access spaces
  assign reg_idx = io_index(io_sel, io_addr);
  assign busy = (state_r == WRITING);
  assign wr_ctl = hit(reg_idx, IO_CONTROL, io_wr);
  assign wr_data = hit(reg_idx, IO_DATA, io_wr);
  assign wr_lo = hit(reg_idx, IO_ADDR_LO, io_wr) && !busy;
  assign wr_hi = hit(reg_idx, IO_ADDR_HI, io_wr) && !busy;
  assign rd_trig = wr_ctl && io_wdata[BIT_READ] && !busy;
  assign wr_start = wr_ctl && io_wdata[BIT_WRITE] && arm_r && !busy
                    && !self_program_active;

  // Address pair; left unreset as software must load it
  always_ff @(posedge ref_clk) begin
    if (ce && wr_lo) begin
      addr_lo_r <= io_wdata;
    end
    if (ce && wr_hi) begin
      addr_hi_r <= io_wdata[HI_ADDR_BITS-1:0];
    end
  end
  assign cell_addr = {addr_hi_r, addr_lo_r};

  // Data buffer: written by CPU, loaded by a read
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      data_r <= DATA_RESET;
    end else if (ce) begin
      if (rd_trig) begin
        data_r <= cell_rdata;
      end else if (wr_data) begin
        data_r <= io_wdata;
      end
    end
  end
  assign cell_wdata = data_r;

  // Interrupt enable bit
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rie_r <= CONTROL_RESET[BIT_RIE];
    end else if (ce && wr_ctl) begin
      rie_r <= io_wdata[BIT_RIE];
    end
  end

  // Arm bit with four-cycle timeout
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      arm_r <= CONTROL_RESET[BIT_ARM];
      arm_cnt_r <= 3'h0;
    end else if (ce) begin
      if (wr_ctl && io_wdata[BIT_ARM] && !arm_r) begin
        arm_r <= 1'b1;
        arm_cnt_r <= ARM_CYCLES - 3'h1;
      end else if (arm_r) begin
        if (arm_cnt_r == 3'h0) begin
          arm_r <= 1'b0;
        end else begin
          arm_cnt_r <= arm_cnt_r - 3'h1;
        end
      end
    end
  end

  // Self-timed write on oscillator ticks
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_r <= IDLE;
      strobe_r <= CONTROL_RESET[BIT_WRITE];
      osc_cnt_r <= 14'h0000;
    end else if (ce) begin
      unique case (state_r)
        IDLE: begin
          if (wr_start) begin
            state_r <= WRITING;
            strobe_r <= 1'b1;
            osc_cnt_r <= 14'(WRITE_OSC_COUNT - 1);
          end
        end
        WRITING: begin
          if (osc_tick) begin
            if (osc_cnt_r == 14'h0000) begin
              state_r <= IDLE;
              strobe_r <= 1'b0;
            end else begin
              osc_cnt_r <= osc_cnt_r - 14'h0001;
            end
          end
        end
        default: begin
          state_r <= IDLE;
        end
      endcase
    end
  end
  assign cell_we = ce && wr_start;
  assign cell_re = ce && rd_trig;

  // CPU stall counter after strobes
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      stall_cnt_r <= 3'h0;
    end else if (ce) begin
      if (rd_trig) begin
        stall_cnt_r <= READ_STALL_CYCLES;
      end else if (wr_start) begin
        stall_cnt_r <= WRITE_STALL_CYCLES;
      end else if (stall_cnt_r != 3'h0) begin
        stall_cnt_r <= stall_cnt_r - 3'h1;
      end
    end
  end
  assign cpu_stall = (stall_cnt_r != 3'h0);

  // Level ready interrupt
  assign ready_irq = rie_r && global_irq_enable && !strobe_r;

  // Register read mux; reserved bits zero, strobe bit 0 reads zero
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      io_rdata <= 8'h00;
    end else if (ce && io_rd) begin
      unique case (reg_idx)
        IO_CONTROL: io_rdata <= {4'h0, rie_r, arm_r, strobe_r, 1'b0};
        IO_DATA: io_rdata <= data_r;
        IO_ADDR_LO: io_rdata <= addr_lo_r;
        IO_ADDR_HI: io_rdata <= {6'h00, addr_hi_r};
        default: io_rdata <= 8'h00;
      endcase
    end
  end

  // Checks
  // Data register as seen from the data space
  localparam logic [6:0] DS_DATA = 7'({1'b0, IO_DATA} + DATA_SPACE_OFFSET);

  // Ticks seen during the current write, for the duration check
  logic [13:0] tick_seen_r;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tick_seen_r <= 14'h0000;
    end else if (ce) begin
      if (wr_start) begin
        tick_seen_r <= 14'h0000;
      end else if (busy && osc_tick) begin
        tick_seen_r <= tick_seen_r + 14'h0001;
      end
    end
  end

  AST_ARM_TIMEOUT: assert property (
    @(posedge ref_clk) disable iff (rst)
    $rose(arm_r) && ce ##1 ce[*3] |=> !arm_r)
    else $error("arm bit did not clear after four cycles");

  AST_ARM_SET: assert property (
    @(posedge ref_clk) disable iff (rst)
    ce && wr_ctl && io_wdata[BIT_ARM] && !arm_r |=> arm_r)
    else $error("arm bit not set by software write");

  AST_NO_WRITE_UNARMED: assert property (
    @(posedge ref_clk) disable iff (rst)
    cell_we |-> arm_r)
    else $error("write started without arm");

  AST_STROBE_ARMED: assert property (
    @(posedge ref_clk) disable iff (rst)
    $rose(strobe_r) |-> $past(arm_r))
    else $error("write strobe set while unarmed");

  AST_WRITE_STALL: assert property (
    @(posedge ref_clk) disable iff (rst)
    ce && wr_start |=> cpu_stall)
    else $error("no stall after write strobe");

  AST_WRITE_STALL_END: assert property (
    @(posedge ref_clk) disable iff (rst)
    ce && wr_start ##1 ce[*2] |=> !cpu_stall)
    else $error("write stall too long");

  AST_READ_STALL: assert property (
    @(posedge ref_clk) disable iff (rst)
    ce && rd_trig ##1 ce[*3] |=> cpu_stall)
    else $error("read stall too short");

  AST_READ_STALL_END: assert property (
    @(posedge ref_clk) disable iff (rst)
    ce && rd_trig ##1 (ce && !rd_trig && !wr_start)[*4] |=> !cpu_stall)
    else $error("read stall too long");

  AST_IRQ_LEVEL: assert property (
    @(posedge ref_clk) disable iff (rst)
    ready_irq |-> !strobe_r && rie_r)
    else $error("irq while write in progress");

  AST_IRQ_RAISE: assert property (
    @(posedge ref_clk) disable iff (rst)
    rie_r && global_irq_enable && !strobe_r |-> ready_irq)
    else $error("ready irq missing while idle");

  AST_IRQ_GATED: assert property (
    @(posedge ref_clk) disable iff (rst)
    !global_irq_enable |-> !ready_irq)
    else $error("irq without global enable");

  AST_RIE_LOAD: assert property (
    @(posedge ref_clk) disable iff (rst)
    ce && wr_ctl |=> rie_r == $past(io_wdata[BIT_RIE]))
    else $error("irq enable bit not loaded");

  AST_NO_READ_BUSY: assert property (
    @(posedge ref_clk) disable iff (rst)
    cell_re |-> !busy)
    else $error("read during write");

  AST_ADDR_FROZEN: assert property (
    @(posedge ref_clk) disable iff (rst)
    busy && $past(busy) |-> $stable(cell_addr))
    else $error("address changed during write");

  AST_ADDR_LOAD_LO: assert property (
    @(posedge ref_clk) disable iff (rst)
    ce && wr_lo |=> addr_lo_r == $past(io_wdata))
    else $error("low address not loaded");

  AST_ADDR_LOAD_HI: assert property (
    @(posedge ref_clk) disable iff (rst)
    ce && wr_hi |=> addr_hi_r == $past(io_wdata[HI_ADDR_BITS-1:0]))
    else $error("high address not loaded");

  AST_DATA_LOAD: assert property (
    @(posedge ref_clk) disable iff (rst)
    ce && wr_data && !rd_trig |=> data_r == $past(io_wdata))
    else $error("data buffer not loaded");

  AST_STROBE_HOLD: assert property (
    @(posedge ref_clk) disable iff (rst)
    $rose(strobe_r) |=> strobe_r[*8])
    else $error("write strobe dropped early");

  AST_STROBE_TICK: assert property (
    @(posedge ref_clk) disable iff (rst)
    $fell(strobe_r) |-> $past(osc_tick))
    else $error("write strobe cleared off a tick");

  AST_OSC_COUNT: assert property (
    @(posedge ref_clk) disable iff (rst)
    $fell(strobe_r) |-> tick_seen_r == 14'(WRITE_OSC_COUNT))
    else $error("write time not equal to tick count");

  AST_READ_DATA: assert property (
    @(posedge ref_clk) disable iff (rst)
    cell_re |=> data_r == $past(cell_rdata))
    else $error("read byte not loaded");

  AST_SPM_BLOCK: assert property (
    @(posedge ref_clk) disable iff (rst)
    cell_we |-> !self_program_active)
    else $error("write during self programming");

  AST_RESERVED_READ: assert property (
    @(posedge ref_clk) disable iff (rst)
    ce && io_rd && reg_idx == IO_CONTROL
    |=> io_rdata[7:4] == 4'h0 && !io_rdata[BIT_READ])
    else $error("reserved control bits not zero");

  AST_DATA_SPACE: assert property (
    @(posedge ref_clk) disable iff (rst)
    !io_sel && io_addr == DS_DATA |-> wr_data == io_wr)
    else $error("data space alias not decoded");

  AST_CE_FREEZE: assert property (
    @(posedge ref_clk) disable iff (rst)
    !ce |=> $stable(state_r) && $stable(arm_r) && $stable(data_r)
    && $stable(stall_cnt_r))
    else $error("state moved with clock enable low");

  // Main scenarios
  COV_WRITE: cover property (@(posedge ref_clk) cell_we);
  COV_READ: cover property (@(posedge ref_clk) cell_re);
  COV_WRITE_DONE: cover property (@(posedge ref_clk) $fell(strobe_r));
  COV_ARM_TIMEOUT: cover property (@(posedge ref_clk) $fell(arm_r));
endmodule

/* File: logic/storage_pkg.sv */
// Constants shared by the storage access controller
package storage_pkg;
  localparam logic [5:0] IO_CONTROL = 6'h1c;
  localparam logic [5:0] IO_DATA = 6'h1d;
  localparam logic [5:0] IO_ADDR_LO = 6'h1e;
  localparam logic [5:0] IO_ADDR_HI = 6'h1f;
  localparam logic [6:0] DATA_SPACE_OFFSET = 7'h20;
  localparam int ADDR_W = 10;
  localparam int BIT_READ = 0;
  localparam int BIT_WRITE = 1;
  localparam int BIT_ARM = 2;
  localparam int BIT_RIE = 3;
  localparam int HI_ADDR_BITS = 2;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [2:0] ARM_CYCLES = 3'h4;
  localparam logic [2:0] WRITE_STALL_CYCLES = 3'h2;
  localparam logic [2:0] READ_STALL_CYCLES = 3'h4;
  localparam int WRITE_OSC_CYCLES = 8448;
  localparam real WRITE_TIME_TYP_MS = 8.5;
  localparam real OSC_FREQ_MHZ = 1.0;
  localparam real CLK_FREQ_MHZ = 40.0;
  localparam int CLK_PER_OSC = int'(CLK_FREQ_MHZ / OSC_FREQ_MHZ);
endpackage

/* File: tb/cell_array_model.sv */
// Behavioural model of the 1 Kbyte storage cell array
`timescale 1ns/1ps
module cell_array_model (
  input wire logic ref_clk,
  input wire logic [9:0] cell_addr,
  input wire logic [7:0] cell_wdata,
  input wire logic cell_we,
  input wire logic cell_re,
  output logic [7:0] cell_rdata
);
  logic [7:0] mem [0:1023];
  initial foreach (mem[i]) mem[i] = 8'h00;
  // Byte stored at the selected address on a write pulse
  always @(posedge ref_clk) begin
    if (cell_we) mem[cell_addr] <= cell_wdata;
  end
  // Outside a read the lines toggle, so a stale value never matches
  assign cell_rdata = cell_re ? mem[cell_addr] : (8'h5a ^ {8{ref_clk}});
endmodule

/* File: tb/testbench.sv */
// Self-checking bench for the storage access controller
`timescale 1ns/1ps
module testbench;
  import storage_pkg::*;
  `define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin errors++; \
    $display("Error at %0t got %h exp %h", $time, g, e); end end
  logic ref_clk = 0, rst = 1, io_sel = 1, io_wr = 0, io_rd = 0;
  logic ce = 1;
  logic gie = 0, spa = 0, cpu_stall, ready_irq, cell_we, cell_re;
  logic [6:0] io_addr = 7'h00;
  logic [7:0] io_wdata = 8'h00, io_rdata, cell_wdata, cell_rdata, q;
  logic [9:0] cell_addr;
  int errors = 0, n_compared = 0, stalls = 0;
  storage_access #(.WRITE_OSC_COUNT(4)) u_storage_access (.ref_clk(ref_clk),
    .rst(rst), .ce(ce), .io_sel(io_sel), .io_addr(io_addr), .io_wr(io_wr),
    .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .global_irq_enable(gie), .self_program_active(spa),
    .cpu_stall(cpu_stall), .ready_irq(ready_irq), .cell_addr(cell_addr),
    .cell_wdata(cell_wdata), .cell_we(cell_we), .cell_re(cell_re),
    .cell_rdata(cell_rdata));
  cell_array_model u_cell_array_model (.ref_clk(ref_clk),
    .cell_addr(cell_addr), .cell_wdata(cell_wdata), .cell_we(cell_we),
    .cell_re(cell_re), .cell_rdata(cell_rdata));
  // Clock and stall-cycle counter
  always #12.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    if (cpu_stall) stalls++;
  end
  // One register access, held for one edge, after any stall ends
  task automatic acc(input logic s, input logic [6:0] a, input logic w,
                     input logic [7:0] d);
    while (cpu_stall) begin
      @(posedge ref_clk);
      #1;
    end
    io_sel = s;
    io_addr = a;
    io_wdata = d;
    io_wr = w;
    io_rd = !w;
    @(posedge ref_clk);
    #1;
    io_wr = 0;
    io_rd = 0;
    q = io_rdata;
    @(posedge ref_clk);
    #1;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    acc(1'b1, a, 1'b1, d);
  endtask
  task automatic rd(input logic [6:0] a);
    acc(1'b1, a, 1'b0, 8'h00);
  endtask
  task automatic conclude;
    if (errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Watchdog
  initial begin
    #100us;
    errors++;
    conclude();
  end
  // Test sequence
  initial begin
    repeat (3) @(posedge ref_clk);
    #1;
    rst = 0;
    rd(7'h1c); `CHK(q, 8'h00)
    rd(7'h1d); `CHK(q, 8'h00)
    wr(7'h1f, 8'hff);
    wr(7'h1e, 8'h5a);
    rd(7'h1f); `CHK(q, 8'h03)
    `CHK(cell_addr, 10'h35a)
    wr(7'h1d, 8'ha5);
    wr(7'h1c, 8'h04);
    rd(7'h1c); `CHK(q, 8'h04)
    repeat (4) @(posedge ref_clk);
    #1;
    rd(7'h1c); `CHK(q, 8'h00)
    wr(7'h1c, 8'h02);
    rd(7'h1c); `CHK(q, 8'h00)
    spa = 1;
    wr(7'h1c, 8'h04);
    wr(7'h1c, 8'h06);
    rd(7'h1c); `CHK(q, 8'h04)
    `CHK(u_cell_array_model.mem[10'h35a], 8'h00)
    spa = 0;
    wr(7'h1c, 8'h04);
    stalls = 0;
    wr(7'h1c, 8'h06);
    rd(7'h1c); `CHK(q, 8'h02)
    `CHK(stalls, 2)
    wr(7'h1e, 8'h00);
    `CHK(cell_addr, 10'h35a)
    repeat (300) if (q[1]) rd(7'h1c);
    `CHK(q, 8'h00)
    `CHK(u_cell_array_model.mem[10'h35a], 8'ha5)
    u_cell_array_model.mem[10'h0c3] = 8'h3c;
    acc(1'b0, 7'h3f, 1'b1, 8'h00);
    acc(1'b0, 7'h3e, 1'b1, 8'hc3);
    stalls = 0;
    wr(7'h1c, 8'h01);
    rd(7'h1d); `CHK(q, 8'h3c)
    `CHK(stalls, 4)
    wr(7'h1c, 8'h08);
    `CHK(ready_irq, 1'b0)
    gie = 1;
    #1;
    `CHK(ready_irq, 1'b1)
    ce = 0;
    wr(7'h1d, 8'h77);
    ce = 1;
    rd(7'h1d); `CHK(q, 8'h3c)
    conclude();
  end
endmodule
